// ===== rtl/iep_cfg.svh
// Register indices, field masks and codes of the interrupt controller
`ifndef IEP_CFG_SVH
`define IEP_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IEP_IDX_FLAGS     8'ha0
`define IEP_IDX_SEL_LO    8'ha4
`define IEP_IDX_SEL_HI    8'ha5
`define IEP_IDX_EN_FIRST  8'ha8
`define IEP_IDX_EN_SECOND 8'ha9
`define IEP_IDX_EN_THIRD  8'haa
`define IEP_IDX_EN_FOURTH 8'hab
`define IEP_IDX_PRIO_LO   8'hb8
`define IEP_IDX_PRIO_HI   8'hf8
`define IEP_IDX_IRQ_STAT  8'hc0
`define IEP_IDX_IRQ_CLR   8'hc1
`define IEP_IDX_IRQ_EN    8'hc2

// ----------------------------------------------------------------
// Writable bit masks and reset value
// ----------------------------------------------------------------
`define IEP_MASK_EN_FIRST  8'hbf
`define IEP_MASK_EN_SECOND 8'h0d
`define IEP_MASK_EN_THIRD  8'h37
`define IEP_MASK_EN_FOURTH 8'h18
`define IEP_MASK_PRIO      8'h3f
`define IEP_MASK_FLAGS     8'h3f
`define IEP_MASK_SEL_LO    8'hff
`define IEP_MASK_SEL_HI    8'h0f
`define IEP_MASK_IRQ       8'h7f
`define IEP_RST_BYTE       8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IEP_BIT_GLOBAL     7
`define IEP_BIT_ADC        0
`define IEP_BIT_LINE_RX    2
`define IEP_BIT_LINE_TX    3
`define IEP_BIT_TMR0       0
`define IEP_BIT_TMR1       1
`define IEP_BIT_SIREN      2
`define IEP_BIT_SER_RX     4
`define IEP_BIT_SER_TX     5
`define IEP_BIT_WDOG       3
`define IEP_BIT_INTERVAL   4
`define IEP_SRC_ADC        6
`define IEP_SRC_LINE_RX    8
`define IEP_SRC_LINE_TX    9
`define IEP_SRC_TMR0       12
`define IEP_SRC_TMR1       13
`define IEP_SRC_SIREN      14
`define IEP_SRC_SER_RX     16
`define IEP_SRC_SER_TX     17
`define IEP_SRC_WDOG       21
`define IEP_SRC_INTERVAL   22

// ----------------------------------------------------------------
// Edge selector codes and bus codes
// ----------------------------------------------------------------
`define IEP_EDGE_NONE      2'h0
`define IEP_EDGE_RISE      2'h1
`define IEP_EDGE_FALL      2'h2
`define IEP_EDGE_BOTH      2'h3
`define IEP_HSIZE_WORD     3'h2
`define IEP_HRESP_OKAY     1'h0

`endif

// ===== rtl/iep_pkg.sv
// Types shared by the interrupt controller modules
package iep_pkg;

	// ----------------------------------------------------------------
	// Bus slave states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IEP_ST_IDLE  = 2'b00,
		IEP_ST_WRITE = 2'b01,
		IEP_ST_READ  = 2'b10,
		IEP_ST_RDONE = 2'b11
	} iep_bus_st_t;

	typedef logic [7:0] iep_byte_t;

endpackage

// ===== rtl/iep_edge_if.sv
// Edge selector and edge hit signals between controller and detector
`timescale 1ns/1ps
interface iep_edge_if;
	logic [11:0] sel;
	logic [5:0]  hit;
	modport det (input sel, output hit);
	modport ctl (output sel, input hit);
endinterface

// ===== rtl/iep_edge_detect.sv
// Synchroniser and edge detector for the six external inputs
`timescale 1ns/1ps
`include "iep_cfg.svh"
module iep_edge_detect #(
	parameter int NEXT = 6
) (
	input  wire logic            clk,
	input  wire logic            nrst,
	input  wire logic [NEXT-1:0] ext_pin,
	iep_edge_if.det              edge_bus
);

	generate
		if (NEXT != 6) begin : g_chk
			$error("iep_edge_detect serves exactly six inputs");
		end
	endgenerate

	logic [NEXT-1:0] sync1_reg, sync2_reg, prev_reg, hit_reg;
	logic [NEXT-1:0] hit_next;

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NEXT; i++) begin
			case (edge_bus.sel[2*i +: 2])
				`IEP_EDGE_RISE: hit_next[i] = sync2_reg[i] & ~prev_reg[i];
				`IEP_EDGE_FALL: hit_next[i] = ~sync2_reg[i] & prev_reg[i];
				`IEP_EDGE_BOTH: hit_next[i] = sync2_reg[i] ^ prev_reg[i];
				default:        hit_next[i] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Two-flop sync, history and hit register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
			hit_reg   <= '0;
		end else begin
			sync1_reg <= ext_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			hit_reg   <= hit_next;
		end
	end

	assign edge_bus.hit = hit_reg;

endmodule

// ===== rtl/iep_irq_ctrl.sv
// Interrupt enable, priority and external edge controller with AHB-Lite slave
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "iep_cfg.svh"
module iep_irq_ctrl #(
	parameter int NSRC = 24,
	parameter int NGRP = 6
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [5:0]  ext_pin,
	input  wire logic [23:0] periph_evt,
	input  wire logic        irq_ack,
	output logic             irq_req,
	output logic      [4:0]  irq_src_id,
	output logic      [1:0]  irq_level,
	output logic             irq_out
);

	generate
		if (NSRC != 24 || NGRP * 4 != NSRC) begin : g_chk
			$error("iep_irq_ctrl serves 24 sources in groups of four");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic iep_pkg::iep_byte_t addr_index(input logic [31:0] a);
		return a[9:2];
	endfunction

	function automatic logic [7:0] pick_winner(input logic [23:0] act,
		input logic [5:0] plo, input logic [5:0] phi);
		logic       found;
		logic [1:0] best;
		logic [1:0] lvl;
		logic [4:0] id;
		found = 1'b0;
		best  = 2'h0;
		id    = 5'h0;
		for (int i = 23; i >= 0; i--) begin
			lvl = {phi[i / 4], plo[i / 4]};
			if (act[i] && (!found || lvl >= best)) begin
				found = 1'b1;
				best  = lvl;
				id    = 5'(i);
			end
		end
		return {found, best, id};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	iep_pkg::iep_bus_st_t st_reg, st_next;
	iep_pkg::iep_byte_t   idx_reg, idx_next;
	logic        hready_reg, hready_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic        hresp_reg;

	iep_pkg::iep_byte_t en1_reg, en1_next;
	iep_pkg::iep_byte_t en2_reg, en2_next;
	iep_pkg::iep_byte_t en3_reg, en3_next;
	iep_pkg::iep_byte_t en4_reg, en4_next;
	iep_pkg::iep_byte_t plo_reg, plo_next;
	iep_pkg::iep_byte_t phi_reg, phi_next;
	iep_pkg::iep_byte_t sel0_reg, sel0_next;
	iep_pkg::iep_byte_t sel1_reg, sel1_next;
	iep_pkg::iep_byte_t ien_reg, ien_next;

	logic [5:0]  ext_reg, ext_next;
	logic [17:0] src_reg, src_next;
	logic [6:0]  stat_reg, stat_next;

	logic       req_reg, req_next;
	logic [4:0] id_reg, id_next;
	logic [1:0] lvl_reg, lvl_next;
	logic       irq_out_reg, irq_out_next;

	logic        addr_ok;
	logic        wr_commit;
	logic [7:0]  wbyte;
	logic [23:0] ack_clr;
	logic [23:0] pend;
	logic [23:0] en_vec;
	logic [23:0] act;
	logic [7:0]  win;

	iep_edge_if edge_bus ();

	// ----------------------------------------------------------------
	// External edge detector
	// ----------------------------------------------------------------
	assign edge_bus.sel = {sel1_reg[3:0], sel0_reg};

	iep_edge_detect #(
		.NEXT (6)
	) u_edge (
		.clk      (clk),
		.nrst     (nrst),
		.ext_pin  (ext_pin),
		.edge_bus (edge_bus)
	);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign addr_ok   = hsel && htrans[1] && hready && hsize == `IEP_HSIZE_WORD;
	assign wr_commit = st_reg == iep_pkg::IEP_ST_WRITE;
	assign wbyte     = hwdata[7:0];

	always_comb begin
		st_next     = st_reg;
		idx_next    = idx_reg;
		hready_next = 1'b1;
		hrdata_next = hrdata_reg;
		case (st_reg)
			iep_pkg::IEP_ST_READ: begin
				hrdata_next = 32'h0;
				case (idx_reg)
					`IEP_IDX_FLAGS:     hrdata_next[7:0] = {2'h0, ext_reg};
					`IEP_IDX_SEL_LO:    hrdata_next[7:0] = sel0_reg;
					`IEP_IDX_SEL_HI:    hrdata_next[7:0] = sel1_reg;
					`IEP_IDX_EN_FIRST:  hrdata_next[7:0] = en1_reg;
					`IEP_IDX_EN_SECOND: hrdata_next[7:0] = en2_reg;
					`IEP_IDX_EN_THIRD:  hrdata_next[7:0] = en3_reg;
					`IEP_IDX_EN_FOURTH: hrdata_next[7:0] = en4_reg;
					`IEP_IDX_PRIO_LO:   hrdata_next[7:0] = plo_reg;
					`IEP_IDX_PRIO_HI:   hrdata_next[7:0] = phi_reg;
					`IEP_IDX_IRQ_STAT:  hrdata_next[7:0] = {1'b0, stat_reg};
					`IEP_IDX_IRQ_EN:    hrdata_next[7:0] = ien_reg;
					default:            hrdata_next[7:0] = `IEP_RST_BYTE;
				endcase
				st_next = iep_pkg::IEP_ST_RDONE;
			end
			iep_pkg::IEP_ST_IDLE, iep_pkg::IEP_ST_WRITE, iep_pkg::IEP_ST_RDONE: begin
				if (addr_ok) begin
					idx_next = addr_index(haddr);
					if (hwrite) begin
						st_next = iep_pkg::IEP_ST_WRITE;
					end else begin
						st_next     = iep_pkg::IEP_ST_READ;
						hready_next = 1'b0;
					end
				end else begin
					st_next = iep_pkg::IEP_ST_IDLE;
				end
			end
			default: begin
				st_next = iep_pkg::IEP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg     <= iep_pkg::IEP_ST_IDLE;
			idx_reg    <= `IEP_RST_BYTE;
			hready_reg <= 1'b1;
			hrdata_reg <= 32'h0;
			hresp_reg  <= `IEP_HRESP_OKAY;
		end else begin
			st_reg     <= st_next;
			idx_reg    <= idx_next;
			hready_reg <= hready_next;
			hrdata_reg <= hrdata_next;
			hresp_reg  <= `IEP_HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		en1_next  = en1_reg;
		en2_next  = en2_reg;
		en3_next  = en3_reg;
		en4_next  = en4_reg;
		plo_next  = plo_reg;
		phi_next  = phi_reg;
		sel0_next = sel0_reg;
		sel1_next = sel1_reg;
		ien_next  = ien_reg;
		if (wr_commit) begin
			case (idx_reg)
				`IEP_IDX_EN_FIRST:  en1_next  = wbyte & `IEP_MASK_EN_FIRST;
				`IEP_IDX_EN_SECOND: en2_next  = wbyte & `IEP_MASK_EN_SECOND;
				`IEP_IDX_EN_THIRD:  en3_next  = wbyte & `IEP_MASK_EN_THIRD;
				`IEP_IDX_EN_FOURTH: en4_next  = wbyte & `IEP_MASK_EN_FOURTH;
				`IEP_IDX_PRIO_LO:   plo_next  = wbyte & `IEP_MASK_PRIO;
				`IEP_IDX_PRIO_HI:   phi_next  = wbyte & `IEP_MASK_PRIO;
				`IEP_IDX_SEL_LO:    sel0_next = wbyte & `IEP_MASK_SEL_LO;
				`IEP_IDX_SEL_HI:    sel1_next = wbyte & `IEP_MASK_SEL_HI;
				`IEP_IDX_IRQ_EN:    ien_next  = wbyte & `IEP_MASK_IRQ;
				default:            ien_next  = ien_reg;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en1_reg  <= `IEP_RST_BYTE;
			en2_reg  <= `IEP_RST_BYTE;
			en3_reg  <= `IEP_RST_BYTE;
			en4_reg  <= `IEP_RST_BYTE;
			plo_reg  <= `IEP_RST_BYTE;
			phi_reg  <= `IEP_RST_BYTE;
			sel0_reg <= `IEP_RST_BYTE;
			sel1_reg <= `IEP_RST_BYTE;
			ien_reg  <= `IEP_RST_BYTE;
		end else begin
			en1_reg  <= en1_next;
			en2_reg  <= en2_next;
			en3_reg  <= en3_next;
			en4_reg  <= en4_next;
			plo_reg  <= plo_next;
			phi_reg  <= phi_next;
			sel0_reg <= sel0_next;
			sel1_reg <= sel1_next;
			ien_reg  <= ien_next;
		end
	end

	// ----------------------------------------------------------------
	// Pending flags and event status
	// ----------------------------------------------------------------
	assign ack_clr = irq_ack ? (24'h000001 << id_reg) : 24'h000000;
	assign pend    = {src_reg, ext_reg};

	always_comb begin
		ext_next  = ext_reg & ~ack_clr[5:0];
		src_next  = src_reg & ~ack_clr[23:6];
		stat_next = stat_reg;
		if (wr_commit && idx_reg == `IEP_IDX_FLAGS) begin
			ext_next = ext_next & wbyte[5:0];
		end
		if (wr_commit && idx_reg == `IEP_IDX_IRQ_CLR) begin
			stat_next = stat_reg & ~wbyte[6:0];
		end
		ext_next  = ext_next | edge_bus.hit;
		src_next  = src_next | periph_evt[23:6];
		stat_next = stat_next | {irq_ack, edge_bus.hit};
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_reg  <= 6'h00;
			src_reg  <= 18'h00000;
			stat_reg <= 7'h00;
		end else begin
			ext_reg  <= ext_next;
			src_reg  <= src_next;
			stat_reg <= stat_next;
		end
	end

	// ----------------------------------------------------------------
	// Enable vector and request selection
	// ----------------------------------------------------------------
	always_comb begin
		en_vec                    = 24'h000000;
		en_vec[5:0]               = en1_reg[5:0];
		en_vec[`IEP_SRC_ADC]      = en2_reg[`IEP_BIT_ADC];
		en_vec[`IEP_SRC_LINE_RX]  = en2_reg[`IEP_BIT_LINE_RX];
		en_vec[`IEP_SRC_LINE_TX]  = en2_reg[`IEP_BIT_LINE_TX];
		en_vec[`IEP_SRC_TMR0]     = en3_reg[`IEP_BIT_TMR0];
		en_vec[`IEP_SRC_TMR1]     = en3_reg[`IEP_BIT_TMR1];
		en_vec[`IEP_SRC_SIREN]    = en3_reg[`IEP_BIT_SIREN];
		en_vec[`IEP_SRC_SER_RX]   = en3_reg[`IEP_BIT_SER_RX];
		en_vec[`IEP_SRC_SER_TX]   = en3_reg[`IEP_BIT_SER_TX];
		en_vec[`IEP_SRC_WDOG]     = en4_reg[`IEP_BIT_WDOG];
		en_vec[`IEP_SRC_INTERVAL] = en4_reg[`IEP_BIT_INTERVAL];
	end

	assign act = pend & en_vec & {24{en1_reg[`IEP_BIT_GLOBAL]}};
	assign win = pick_winner(act, plo_reg[5:0], phi_reg[5:0]);

	always_comb begin
		req_next     = win[7];
		lvl_next     = win[6:5];
		id_next      = win[4:0];
		irq_out_next = |(stat_reg & ien_reg[6:0]);
		if (!win[7]) begin
			lvl_next = lvl_reg;
			id_next  = id_reg;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_reg     <= 1'b0;
			id_reg      <= 5'h00;
			lvl_reg     <= 2'h0;
			irq_out_reg <= 1'b0;
		end else begin
			req_reg     <= req_next;
			id_reg      <= id_next;
			lvl_reg     <= lvl_next;
			irq_out_reg <= irq_out_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata     = hrdata_reg;
	assign hreadyout  = hready_reg;
	assign hresp      = hresp_reg;
	assign irq_req    = req_reg;
	assign irq_src_id = id_reg;
	assign irq_level  = lvl_reg;
	assign irq_out    = irq_out_reg;

endmodule

// ===== test/iep_irq_sva.sv
// Port checker of the interrupt controller
`timescale 1ns/1ps
`include "iep_cfg.svh"
module iep_irq_sva (
	input logic        clk,
	input logic        nrst,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic        irq_ack,
	input logic        irq_req,
	input logic [4:0]  irq_src_id,
	input logic [1:0]  irq_level,
	input logic        irq_out
);
	// ----------------
	// Register shadows
	// ----------------
	logic        wr_take, rd_take, wr_pend_reg;
	logic [7:0]  wr_idx_reg, rd_idx_reg, rd_mask;
	logic [7:0]  sh_reg [256];
	logic [23:0] en_all;
	assign wr_take = hsel && htrans[1] && hready && hsize == `IEP_HSIZE_WORD && hwrite;
	assign rd_take = hsel && htrans[1] && hready && hsize == `IEP_HSIZE_WORD && !hwrite;
	assign en_all = {sh_reg[8'hab][5:0], sh_reg[8'haa][5:0], sh_reg[8'ha9][5:0],
		sh_reg[8'ha8][5:0]};
	always_comb begin
		case (rd_idx_reg)
			8'ha5: rd_mask = `IEP_MASK_SEL_HI;
			8'ha8: rd_mask = `IEP_MASK_EN_FIRST;
			8'ha9: rd_mask = `IEP_MASK_EN_SECOND;
			8'haa: rd_mask = `IEP_MASK_EN_THIRD;
			8'hab: rd_mask = `IEP_MASK_EN_FOURTH;
			8'hb8, 8'hf8, 8'ha0: rd_mask = `IEP_MASK_PRIO;
			8'hc1: rd_mask = 8'h00;
			default: rd_mask = 8'hff;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			rd_idx_reg  <= 8'h00;
			for (int i = 0; i < 256; i++)
				sh_reg[i] <= 8'h00;
		end else begin
			wr_pend_reg <= wr_take;
			if (wr_take)
				wr_idx_reg <= haddr[9:2];
			if (rd_take)
				rd_idx_reg <= haddr[9:2];
			if (wr_pend_reg)
				sh_reg[wr_idx_reg] <= hwdata[7:0];
		end
	end
	// ----------
	// Assertions
	// ----------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	gate_enable_a: assert property (
		irq_req && !$past(wr_pend_reg) |-> sh_reg[8'ha8][7] && en_all[irq_src_id])
		else $error("request from a disabled source");
	level_match_a: assert property (
		irq_req && !$past(wr_pend_reg) |-> irq_level ==
		{sh_reg[8'hf8][irq_src_id[4:2]], sh_reg[8'hb8][irq_src_id[4:2]]})
		else $error("level differs from group priority");
	req_hold_a: assert property (
		irq_req && !irq_ack && !$past(irq_ack) && !wr_pend_reg && !$past(wr_pend_reg)
		|=> irq_req) else $error("request dropped without acceptance");
	src_range_a: assert property (irq_req |-> irq_src_id <= 5'h17)
		else $error("source number out of range");
	unused_read_a: assert property (
		rd_take |-> ##2 (hrdata[7:0] & ~rd_mask) == 8'h00)
		else $error("unused bit reads one");
	read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (wr_take |=> hreadyout)
		else $error("write stalled");
	resp_upper_a: assert property (hresp == 1'b0 && hrdata[31:8] == 24'h000000)
		else $error("response or upper data wrong");
	cover property (irq_ack && irq_req);
	cover property ($rose(irq_out));
	cover property (rd_take ##2 hrdata[7:0] != 8'h00);
endmodule

bind iep_irq_ctrl iep_irq_sva chk_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq_ack, .irq_req, .irq_src_id,
	.irq_level, .irq_out);

// ===== test/iep_core_model.sv
// Core stand-in that accepts interrupt requests
`timescale 1ns/1ps
module iep_core_model (
	input  logic       clk,
	input  logic       nrst,
	input  logic       irq_req,
	input  logic       ack_en,
	input  logic [3:0] lag,
	output logic       irq_ack
);
	// -----------------
	// Acceptance timing
	// -----------------
	logic [3:0] wait_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_ack  <= 1'b0;
			wait_reg <= 4'h0;
		end else if (irq_ack) begin
			irq_ack  <= 1'b0;
			wait_reg <= lag + 4'h3;
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
		end else begin
			irq_ack <= ack_en && irq_req;
		end
	end
endmodule

// ===== test/iep_irq_ctrl_test.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
module iep_irq_ctrl_test;
	// -------------------
	// Signals and helpers
	// -------------------
	logic        clk, nrst, hsel, hwrite, hresp, hreadyout;
	logic        irq_ack, irq_req, irq_out, ack_en;
	logic [1:0]  htrans, irq_level;
	logic [2:0]  hsize;
	logic [3:0]  lag;
	logic [4:0]  irq_src_id;
	logic [5:0]  ext_pin;
	logic [23:0] periph_evt;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [6:0]  ack_q[$];
	int          n_mismatch, n_compared;
	logic [7:0]  idx_t[12] = '{8'ha4, 8'ha5, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hb8, 8'hf8,
		8'hc2, 8'h10, 8'ha0, 8'hc1};
	logic [7:0]  msk_t[12] = '{8'hff, 8'h0f, 8'hbf, 8'h0d, 8'h37, 8'h18, 8'h3f, 8'h3f,
		8'h7f, 8'h00, 8'h00, 8'h00};
	iep_irq_ctrl dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_pin, .periph_evt, .irq_ack,
		.irq_req, .irq_src_id, .irq_level, .irq_out);
	iep_core_model core_u (.clk, .nrst, .irq_req, .ack_en, .lag, .irq_ack);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (irq_ack === 1'b1)
			ack_q.push_back({irq_level, irq_src_id});
	end
	task automatic end_sim;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'h0};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, e, rd);
	endtask
	task automatic round(input logic [3:0] lg, input logic [7:0] plo, input logic [7:0] phi,
		input logic [27:0] ex);
		ack_q.delete();
		lag <= lg;
		xfer(1'b1, 8'hb8, plo);
		xfer(1'b1, 8'hf8, phi);
		xfer(1'b1, 8'ha8, 8'h01);
		periph_evt <= 24'h201040;
		ext_pin[0] <= 1'b1;
		@(posedge clk);
		periph_evt <= 24'h000000;
		repeat (8) @(posedge clk);
		chk("req masked", 32'h0, 32'(irq_req));
		xfer(1'b1, 8'ha8, 8'h81);
		repeat (6) @(posedge clk);
		chk("req level", 32'h1, 32'(irq_req));
		chk("winner", 32'(ex[27:21]), {25'h0, irq_level, irq_src_id});
		ack_en <= 1'b1;
		for (int i = 0; i < 300 && ack_q.size() < 4; i++)
			@(posedge clk);
		ack_en <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++)
			chk("ack order", 32'(ex[27 - 7 * i -: 7]), 32'(ack_q[i]));
		chk("req done", 32'h0, 32'(irq_req));
		rdc(8'ha0, 32'h0, "flag acked");
		ext_pin[0] <= 1'b0;
	endtask
	// -----
	// Tests
	// -----
	initial begin
		{nrst, hsel, hwrite, ack_en, htrans, lag, ext_pin, periph_evt} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 12; i++)
			rdc(idx_t[i], 32'h0, "reset value");
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, idx_t[i], 8'hff);
			rdc(idx_t[i], 32'(msk_t[i]), "field mask");
			xfer(1'b1, idx_t[i], 8'h00);
		end
		for (int n = 0; n < 6; n++) begin
			for (int c = 0; c < 4; c++) begin
				xfer(1'b1, n < 4 ? 8'ha4 : 8'ha5, 8'(c) << (2 * (n % 4)));
				ext_pin[n] <= 1'b1;
				repeat (6) @(posedge clk);
				rdc(8'ha0, {31'h0, c[0]} << n, "flag rise");
				xfer(1'b1, 8'ha0, 8'hff);
				rdc(8'ha0, {31'h0, c[0]} << n, "flag write one");
				ext_pin[n] <= 1'b0;
				repeat (6) @(posedge clk);
				rdc(8'ha0, {31'h0, c[0] | c[1]} << n, "flag fall");
				xfer(1'b1, 8'ha0, 8'h00);
				rdc(8'ha0, 32'h0, "flag clear");
			end
		end
		rdc(8'hc0, 32'h3f, "edge status");
		xfer(1'b1, 8'hc1, 8'h3f);
		rdc(8'hc0, 32'h0, "status clear");
		xfer(1'b1, 8'ha9, 8'h01);
		xfer(1'b1, 8'haa, 8'h01);
		xfer(1'b1, 8'hab, 8'h08);
		xfer(1'b1, 8'ha4, 8'h01);
		round(4'h0, 8'h22, 8'h28, {2'h3, 5'h15, 2'h2, 5'h0c, 2'h1, 5'h06, 2'h0, 5'h00});
		round(4'h5, 8'h00, 8'h3f, {2'h2, 5'h00, 2'h2, 5'h06, 2'h2, 5'h0c, 2'h2, 5'h15});
		rdc(8'hc0, 32'h41, "ack status");
		repeat (3) @(posedge clk);
		chk("irq out masked", 32'h0, 32'(irq_out));
		xfer(1'b1, 8'hc2, 8'h40);
		repeat (3) @(posedge clk);
		chk("irq out on", 32'h1, 32'(irq_out));
		xfer(1'b1, 8'hc1, 8'h40);
		repeat (3) @(posedge clk);
		chk("irq out cleared", 32'h0, 32'(irq_out));
		rdc(8'hc0, 32'h01, "status cleared");
		end_sim();
	end
	initial begin
		#(25 * 30000);
		n_mismatch++;
		end_sim();
	end
endmodule
